// ---- verilog/msrc_pkg.sv ----
package msrc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam logic [11:0] OFF_RESET_A     = 12'h040;
  localparam logic [11:0] OFF_RESET_B     = 12'h044;
  localparam logic [11:0] OFF_PORT_GATE   = 12'h128;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h400;
  localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h404;
  localparam logic [11:0] OFF_IRQ_CLEAR   = 12'h408;
  localparam logic [11:0] OFF_FAULT_INFO  = 12'h40C;

  // ----------------------------------------------------------------
  // reset values and writable fields
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_A_INIT    = 32'h0000_0000;
  localparam logic [31:0] RESET_B_INIT    = 32'h0000_0000;
  localparam logic [5:0]  PORT_GATE_INIT  = 6'h00;
  localparam logic [31:0] RESET_A_FIELDS  = 32'h0003_0008;
  localparam logic [31:0] RESET_B_FIELDS  = 32'h570F_5337;

  // ----------------------------------------------------------------
  // field positions, register a
  // ----------------------------------------------------------------
  localparam int BIT_CONVERTER_UNIT1 = 17;
  localparam int BIT_CONVERTER_UNIT0 = 16;
  localparam int BIT_WATCHDOG_UNIT   = 3;

  // ----------------------------------------------------------------
  // field positions, register b
  // ----------------------------------------------------------------
  localparam int BIT_EXT_PERIPH_IF   = 30;
  localparam int BIT_AUDIO_SERIAL    = 28;
  localparam int BIT_COMPARATOR0     = 24;
  localparam int BIT_GP_COUNTER0     = 16;
  localparam int BIT_TWOWIRE_UNIT_B  = 14;
  localparam int BIT_TWOWIRE_UNIT_A  = 12;
  localparam int BIT_ENCODER_UNIT1   = 9;
  localparam int BIT_ENCODER_UNIT0   = 8;
  localparam int BIT_SYNC_SERIAL0    = 4;
  localparam int BIT_ASYNC_SERIAL0   = 0;

  // ----------------------------------------------------------------
  // ports and interrupt events
  // ----------------------------------------------------------------
  localparam int          NUM_PORTS       = 6;
  localparam int          NUM_EVENTS      = 3;
  localparam int          EV_PORT_FAULT   = 0;
  localparam int          EV_BAD_ADDR     = 1;
  localparam int          EV_MASKED_WRITE = 2;
  localparam logic [2:0]  IRQ_INIT        = 3'h0;

endpackage : msrc_pkg

// ---- verilog/msrc_sync_reset.sv ----
`timescale 1ns/1ps
// registered synchronous reset fan-out, one flop per control bit
module msrc_sync_reset #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // control bits and resulting resets
  input  wire logic [WIDTH-1:0] ctrlBits,
  output logic      [WIDTH-1:0] moduleReset
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gen_rst
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          moduleReset[g] <= 1'b1;
        else
          moduleReset[g] <= ctrlBits[g];
      end
    end
  endgenerate

endmodule : msrc_sync_reset

// ---- verilog/msrc_port_guard.sv ----
`timescale 1ns/1ps
// flags port accesses aimed at an unclocked port
module msrc_port_guard (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // port access request
  input  wire logic       portAccess,
  input  wire logic [2:0] portSelect,
  input  wire logic [5:0] portGate,
  // fault answer
  output logic            busFault,
  output logic            portDone,
  output logic [2:0]      faultPort
);

  logic gated;

  // out-of-range select counts as unclocked
  always_comb
  begin
    gated = 1'b0;
    if (portSelect < 3'(msrc_pkg::NUM_PORTS))
      gated = ~portGate[portSelect];
    else
      gated = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busFault  <= 1'b0;
      portDone  <= 1'b0;
      faultPort <= 3'h0;
    end
    else
    begin
      busFault <= portAccess & gated;
      portDone <= portAccess & ~gated;
      if (portAccess & gated)
        faultPort <= portSelect;
    end
  end

endmodule : msrc_port_guard

// ---- verilog/msrc_soft_reset_control.sv ----
`timescale 1ns/1ps
// Behaviour
// - port clock enables at bits 5..0 for ports F..A, reset to zero.
// - access to an unclocked port returns a bus fault, not completion.
// - first reset register at 0x040, read/write, resets to zero.
// - second reset register at 0x044, read/write, resets to zero.
// - reset register writes masked by capability inputs; absent modules ignore writes.
// - module held in reset while its bit is set.
// - first register bits 15:4 and 2:0 read zero, ignore writes.
// - first register bits 17, 16, 3 reset converters 1, 0 and watchdog.
// - second register bits 30, 28, 26..24 reset ext iface, audio, comparators.
// - second register bits 19..16 reset counters 3..0; 23:20 read zero.
// - bits 14, 12 reset two-wire units; bits 9, 8 reset encoders.
// - bits 5, 4 reset sync serial; bits 2..0 reset async serial.
// - second register reserved positions read zero and ignore writes.
// - bit 0 of second register holds async serial unit 0 in reset.
module msrc_soft_reset_control (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  // device capabilities
  input  wire logic [31:0] capabilityMaskA,
  input  wire logic [31:0] capabilityMaskB,
  // port access check
  input  wire logic        portAccess,
  input  wire logic [2:0]  portSelect,
  output logic             portBusFault,
  output logic             portAccessDone,
  // port clock enables
  output logic             portAClockGate,
  output logic             portBClockGate,
  output logic             portCClockGate,
  output logic             portDClockGate,
  output logic             portEClockGate,
  output logic             portFClockGate,
  // module resets, register a
  output logic             converterUnit1Reset,
  output logic             converterUnit0Reset,
  output logic             watchdogUnitReset,
  // module resets, register b
  output logic             extPeriphIfReset,
  output logic             audioSerialReset,
  output logic [2:0]       comparatorUnitReset,
  output logic [3:0]       gpCounterReset,
  output logic             twowireUnitBReset,
  output logic             twowireUnitAReset,
  output logic             encoderUnit1Reset,
  output logic             encoderUnit0Reset,
  output logic [1:0]       syncSerialReset,
  output logic [2:0]       asyncSerialReset,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] moduleResetCtrlA;
  logic [31:0] moduleResetCtrlB;
  logic [5:0]  portGate;
  logic [2:0]  irqStatus;
  logic [2:0]  irqEnable;
  logic [31:0] resetA;
  logic [31:0] resetB;
  logic        fault;
  logic [2:0]  faultPort;
  logic        badAddr;
  logic        maskedWrite;
  logic [2:0]  events;
  logic [2:0]  clearBits;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == msrc_pkg::OFF_RESET_A) || (a == msrc_pkg::OFF_RESET_B)
            || (a == msrc_pkg::OFF_PORT_GATE) || (a == msrc_pkg::OFF_IRQ_STATUS)
            || (a == msrc_pkg::OFF_IRQ_ENABLE) || (a == msrc_pkg::OFF_IRQ_CLEAR)
            || (a == msrc_pkg::OFF_FAULT_INFO);
  endfunction : isMapped

  // writable bits of a reset register after capability masking
  function automatic logic [31:0] maskedField(input logic [31:0] d,
                                              input logic [31:0] fields,
                                              input logic [31:0] cap);
    maskedField = d & fields & cap;
  endfunction : maskedField

  // ----------------------------------------------------------------
  // reset control registers
  // ----------------------------------------------------------------
  // bits stay until software writes them back to zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      moduleResetCtrlA <= msrc_pkg::RESET_A_INIT;
    else if (regWrite && regAddr == msrc_pkg::OFF_RESET_A)
      moduleResetCtrlA <= maskedField(regWrData, msrc_pkg::RESET_A_FIELDS, capabilityMaskA);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      moduleResetCtrlB <= msrc_pkg::RESET_B_INIT;
    else if (regWrite && regAddr == msrc_pkg::OFF_RESET_B)
      moduleResetCtrlB <= maskedField(regWrData, msrc_pkg::RESET_B_FIELDS, capabilityMaskB);
  end

  // ----------------------------------------------------------------
  // port clock gating
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      portGate <= msrc_pkg::PORT_GATE_INIT;
    else if (regWrite && regAddr == msrc_pkg::OFF_PORT_GATE)
      portGate <= regWrData[5:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      portAClockGate <= 1'b0;
      portBClockGate <= 1'b0;
      portCClockGate <= 1'b0;
      portDClockGate <= 1'b0;
      portEClockGate <= 1'b0;
      portFClockGate <= 1'b0;
    end
    else
    begin
      portAClockGate <= portGate[0];
      portBClockGate <= portGate[1];
      portCClockGate <= portGate[2];
      portDClockGate <= portGate[3];
      portEClockGate <= portGate[4];
      portFClockGate <= portGate[5];
    end
  end

  msrc_port_guard u_guard (
    .clk        (clk),
    .rst        (rst),
    .portAccess (portAccess),
    .portSelect (portSelect),
    .portGate   (portGate),
    .busFault   (fault),
    .portDone   (portAccessDone),
    .faultPort  (faultPort)
  );

  assign portBusFault = fault;

  // ----------------------------------------------------------------
  // module reset outputs
  // ----------------------------------------------------------------
  msrc_sync_reset #(.WIDTH(32)) u_rst_a (
    .clk         (clk),
    .rst         (rst),
    .ctrlBits    (moduleResetCtrlA),
    .moduleReset (resetA)
  );

  msrc_sync_reset #(.WIDTH(32)) u_rst_b (
    .clk         (clk),
    .rst         (rst),
    .ctrlBits    (moduleResetCtrlB),
    .moduleReset (resetB)
  );

  // resets are held while the bit stands, released on clear
  always_comb
  begin
    converterUnit1Reset = resetA[msrc_pkg::BIT_CONVERTER_UNIT1];
    converterUnit0Reset = resetA[msrc_pkg::BIT_CONVERTER_UNIT0];
    watchdogUnitReset   = resetA[msrc_pkg::BIT_WATCHDOG_UNIT];
    extPeriphIfReset    = resetB[msrc_pkg::BIT_EXT_PERIPH_IF];
    audioSerialReset    = resetB[msrc_pkg::BIT_AUDIO_SERIAL];
    comparatorUnitReset = resetB[msrc_pkg::BIT_COMPARATOR0 +: 3];
    gpCounterReset      = resetB[msrc_pkg::BIT_GP_COUNTER0 +: 4];
    twowireUnitBReset   = resetB[msrc_pkg::BIT_TWOWIRE_UNIT_B];
    twowireUnitAReset   = resetB[msrc_pkg::BIT_TWOWIRE_UNIT_A];
    encoderUnit1Reset   = resetB[msrc_pkg::BIT_ENCODER_UNIT1];
    encoderUnit0Reset   = resetB[msrc_pkg::BIT_ENCODER_UNIT0];
    syncSerialReset     = resetB[msrc_pkg::BIT_SYNC_SERIAL0 +: 2];
    asyncSerialReset    = resetB[msrc_pkg::BIT_ASYNC_SERIAL0 +: 3];
  end

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  always_comb
  begin
    badAddr     = (regWrite | regRead) & ~isMapped(regAddr);
    maskedWrite = regWrite && (
                  (regAddr == msrc_pkg::OFF_RESET_A &&
                   ((regWrData & msrc_pkg::RESET_A_FIELDS & ~capabilityMaskA) != 32'h0000_0000)) ||
                  (regAddr == msrc_pkg::OFF_RESET_B &&
                   ((regWrData & msrc_pkg::RESET_B_FIELDS & ~capabilityMaskB) != 32'h0000_0000)));
    events      = 3'h0;
    events[msrc_pkg::EV_PORT_FAULT]   = fault;
    events[msrc_pkg::EV_BAD_ADDR]     = badAddr;
    events[msrc_pkg::EV_MASKED_WRITE] = maskedWrite;
    clearBits   = 3'h0;
    if (regWrite && regAddr == msrc_pkg::OFF_IRQ_CLEAR)
      clearBits = regWrData[2:0];
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irqStatus <= msrc_pkg::IRQ_INIT;
    else
      irqStatus <= (irqStatus & ~clearBits) | events;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irqEnable <= msrc_pkg::IRQ_INIT;
    else if (regWrite && regAddr == msrc_pkg::OFF_IRQ_ENABLE)
      irqEnable <= regWrData[2:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(((irqStatus & ~clearBits) | events) & irqEnable);
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdData <= 32'h0000_0000;
    else if (regRead)
    begin
      case (regAddr)
        msrc_pkg::OFF_RESET_A:    regRdData <= moduleResetCtrlA;
        msrc_pkg::OFF_RESET_B:    regRdData <= moduleResetCtrlB;
        msrc_pkg::OFF_PORT_GATE:  regRdData <= {26'h0, portGate};
        msrc_pkg::OFF_IRQ_STATUS: regRdData <= {29'h0, irqStatus};
        msrc_pkg::OFF_IRQ_ENABLE: regRdData <= {29'h0, irqEnable};
        msrc_pkg::OFF_FAULT_INFO: regRdData <= {29'h0, faultPort};
        default:                  regRdData <= 32'h0000_0000;
      endcase
    end
    else
      regRdData <= 32'h0000_0000;
  end

endmodule : msrc_soft_reset_control

// ---- sim/msrc_soft_reset_control_asserts.sv ----
`timescale 1ns/1ps
module msrc_soft_reset_control_asserts (
  // clock, reset and register port
  input wire logic        clk, rst, regWrite, regRead,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData, regRdData, capabilityMaskA, capabilityMaskB,
  // port check
  input wire logic        portAccess, portBusFault, portAccessDone,
  input wire logic [2:0]  portSelect,
  // clock enables and resets
  input wire logic        portAClockGate, portBClockGate, portCClockGate,
  input wire logic        portDClockGate, portEClockGate, portFClockGate,
  input wire logic        converterUnit1Reset, converterUnit0Reset, watchdogUnitReset,
  input wire logic        extPeriphIfReset, audioSerialReset, twowireUnitBReset, twowireUnitAReset,
  input wire logic        encoderUnit1Reset, encoderUnit0Reset, irq,
  input wire logic [2:0]  comparatorUnitReset, asyncSerialReset,
  input wire logic [3:0]  gpCounterReset,
  input wire logic [1:0]  syncSerialReset
);
  logic [5:0]  gates;
  logic [31:0] resA;
  logic [31:0] resB;
  assign gates = {portFClockGate, portEClockGate, portDClockGate, portCClockGate, portBClockGate, portAClockGate};
  assign resA = {14'h0, converterUnit1Reset, converterUnit0Reset, 12'h0, watchdogUnitReset, 3'h0};
  assign resB = {1'b0, extPeriphIfReset, 1'b0, audioSerialReset, 1'b0, comparatorUnitReset, 4'h0, gpCounterReset,
                 1'b0, twowireUnitBReset, 1'b0, twowireUnitAReset, 2'h0, encoderUnit1Reset, encoderUnit0Reset,
                 2'h0, syncSerialReset, 1'b0, asyncSerialReset};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_port_fault: assert property (portAccess && portSelect < 3'h6 |=> portBusFault == !gates[$past(portSelect)])
    else $error("port fault disagrees with clock gate");
  a_port_done: assert property (portAccess && portSelect < 3'h6 |=> portAccessDone == gates[$past(portSelect)])
    else $error("port completion disagrees with clock gate");
  a_bad_port: assert property (portAccess && portSelect > 3'h5 |=> portBusFault && !portAccessDone)
    else $error("missing port gives no fault");
  a_port_quiet: assert property (!portAccess |=> !portBusFault && !portAccessDone)
    else $error("port answer without request");
  a_resv_a: assert property (regRead && regAddr == msrc_pkg::OFF_RESET_A |=> (regRdData & ~msrc_pkg::RESET_A_FIELDS) == 32'h0)
    else $error("reserved bits set in first reset register");
  a_resv_b: assert property (regRead && regAddr == msrc_pkg::OFF_RESET_B |=> (regRdData & ~msrc_pkg::RESET_B_FIELDS) == 32'h0)
    else $error("reserved bits set in second reset register");
  a_write_a: assert property (regWrite && regAddr == msrc_pkg::OFF_RESET_A |-> ##2 resA == ($past(regWrData, 2) & $past(capabilityMaskA, 2) & msrc_pkg::RESET_A_FIELDS))
    else $error("first reset outputs wrong after write");
  a_write_b: assert property (regWrite && regAddr == msrc_pkg::OFF_RESET_B |-> ##2 resB == ($past(regWrData, 2) & $past(capabilityMaskB, 2) & msrc_pkg::RESET_B_FIELDS))
    else $error("second reset outputs wrong after write");
  a_hold_a: assert property ($changed(resA) && !$past(rst) && !$past(rst, 2) |-> $past(regWrite && regAddr == msrc_pkg::OFF_RESET_A, 2))
    else $error("first reset outputs moved without write");
  a_hold_b: assert property ($changed(resB) && !$past(rst) && !$past(rst, 2) |-> $past(regWrite && regAddr == msrc_pkg::OFF_RESET_B, 2))
    else $error("second reset outputs moved without write");
  a_gate_lag: assert property (regWrite && regAddr == msrc_pkg::OFF_PORT_GATE |-> ##2 {26'h0, gates} == ($past(regWrData, 2) & 32'h3F))
    else $error("clock gates wrong after write");
  c_fault: cover property (portAccess ##1 portBusFault);
  c_done: cover property (portAccess ##1 portAccessDone);
  c_held: cover property (asyncSerialReset[0] [*8]);
endmodule : msrc_soft_reset_control_asserts

bind msrc_soft_reset_control msrc_soft_reset_control_asserts chk_u (.*);

// ---- sim/msrc_periph_model.sv ----
`timescale 1ns/1ps
// stand-in for the peripherals fed by the block
module msrc_periph_model (
  // clock
  input  wire logic        clk,
  // resets from the block
  input  wire logic [31:0] resA,
  input  wire logic [31:0] resB,
  // per-module state, lost while held in reset
  output logic      [63:0] alive
);
  always_ff @(posedge clk)
    alive <= ~{resA, resB};
endmodule : msrc_periph_model

// ---- sim/msrc_soft_reset_control_tb.sv ----
`timescale 1ns/1ps
module msrc_soft_reset_control_tb;
  logic        clk, rst, regWrite, regRead, portAccess, irq, rdLate, pLate;
  logic        portBusFault, portAccessDone, portAClockGate, portBClockGate, portCClockGate, portDClockGate;
  logic        portEClockGate, portFClockGate, converterUnit1Reset, converterUnit0Reset, watchdogUnitReset;
  logic        extPeriphIfReset, audioSerialReset, twowireUnitBReset, twowireUnitAReset;
  logic        encoderUnit1Reset, encoderUnit0Reset;
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, capabilityMaskA, capabilityMaskB, resA, resB, seed, d;
  logic [2:0]  portSelect, comparatorUnitReset, asyncSerialReset;
  logic [3:0]  gpCounterReset;
  logic [1:0]  syncSerialReset;
  logic [5:0]  gates, gv;
  logic [63:0] alive;
  logic [31:0] rdQ[$];
  logic [1:0]  pQ[$];
  int          errCount, nTests;

  assign gates = {portFClockGate, portEClockGate, portDClockGate, portCClockGate, portBClockGate, portAClockGate};
  assign resA = {14'h0, converterUnit1Reset, converterUnit0Reset, 12'h0, watchdogUnitReset, 3'h0};
  assign resB = {1'b0, extPeriphIfReset, 1'b0, audioSerialReset, 1'b0, comparatorUnitReset, 4'h0, gpCounterReset,
                 1'b0, twowireUnitBReset, 1'b0, twowireUnitAReset, 2'h0, encoderUnit1Reset, encoderUnit0Reset,
                 2'h0, syncSerialReset, 1'b0, asyncSerialReset};

  msrc_soft_reset_control dut_u (.*);
  msrc_periph_model model_u (.clk(clk), .resA(resA), .resB(resB), .alive(alive));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // compare, bus tasks, verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrapUp

  // read data and port answers checked in their answer cycle
  always @(posedge clk)
  begin
    rdLate <= regRead;
    pLate <= portAccess;
  end
  always @(negedge clk)
  begin
    if (rdLate)
      chk(regRdData, rdQ.pop_front());
    if (pLate)
      chk({30'h0, portBusFault, portAccessDone}, {30'h0, pQ.pop_front()});
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errCount++;
    wrapUp();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'hFB01A463;
    {rst, regWrite, regRead, portAccess} = 4'h8;
    {regAddr, regWrData, portSelect} = '0;
    capabilityMaskA = '1;
    capabilityMaskB = '1;
    repeat (3) @(posedge clk);
    #1;
    chk(resB, msrc_pkg::RESET_B_FIELDS);
    @(posedge clk);
    rst <= 1'b0;
    rd(msrc_pkg::OFF_RESET_A, 32'h0);
    rd(msrc_pkg::OFF_RESET_B, 32'h0);
    rd(msrc_pkg::OFF_PORT_GATE, 32'h0);
    wr(msrc_pkg::OFF_RESET_A, 32'hFFFFFFFF);
    wr(msrc_pkg::OFF_RESET_B, 32'hFFFFFFFF);
    rd(msrc_pkg::OFF_RESET_A, msrc_pkg::RESET_A_FIELDS);
    rd(msrc_pkg::OFF_RESET_B, msrc_pkg::RESET_B_FIELDS);
    repeat (50) @(posedge clk);
    #1;
    chk(resA, 32'h0003_0008);
    chk(resB, 32'h570F_5337);
    chk(alive[31:0] & msrc_pkg::RESET_B_FIELDS, 32'h0);
    chk(alive[63:32] & msrc_pkg::RESET_A_FIELDS, 32'h0);
    for (int i = 0; i < 64; i++)
    begin
      d = 32'h1 << i[4:0];
      wr(i < 32 ? msrc_pkg::OFF_RESET_A : msrc_pkg::OFF_RESET_B, d);
      settle();
      chk(i < 32 ? resA : resB, d & (i < 32 ? msrc_pkg::RESET_A_FIELDS : msrc_pkg::RESET_B_FIELDS));
    end
    repeat (8)
    begin
      @(posedge clk);
      capabilityMaskA <= $random(seed);
      capabilityMaskB <= $random(seed);
      d = $random(seed);
      wr(msrc_pkg::OFF_RESET_A, d);
      wr(msrc_pkg::OFF_RESET_B, d);
      rd(msrc_pkg::OFF_RESET_A, d & capabilityMaskA & msrc_pkg::RESET_A_FIELDS);
      rd(msrc_pkg::OFF_RESET_B, d & capabilityMaskB & msrc_pkg::RESET_B_FIELDS);
    end
    wr(msrc_pkg::OFF_RESET_A, 32'h0);
    wr(msrc_pkg::OFF_RESET_B, 32'h0);
    settle();
    chk(resA | resB, 32'h0);
    gv = 6'($random(seed));
    for (int p = 0; p < 2; p++)
    begin
      wr(msrc_pkg::OFF_PORT_GATE, {26'h0, gv});
      rd(msrc_pkg::OFF_PORT_GATE, {26'h0, gv});
      chk({26'h0, gates}, {26'h0, gv});
      for (int s = 0; s < 8; s++)
      begin
        @(posedge clk);
        portAccess <= 1'b1;
        portSelect <= s[2:0];
        pQ.push_back((s < 6 && gv[s[2:0]]) ? 2'b01 : 2'b10);
      end
      @(posedge clk);
      portAccess <= 1'b0;
      gv = ~gv;
    end
    rd(msrc_pkg::OFF_FAULT_INFO, 32'h7);
    wr(msrc_pkg::OFF_IRQ_CLEAR, 32'h7);
    wr(msrc_pkg::OFF_IRQ_ENABLE, 32'h2);
    rd(12'h7F0, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h1);
    rd(msrc_pkg::OFF_IRQ_STATUS, 32'h2);
    wr(msrc_pkg::OFF_IRQ_ENABLE, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(msrc_pkg::OFF_IRQ_ENABLE, 32'h2);
    wr(msrc_pkg::OFF_IRQ_CLEAR, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h0);
    rd(msrc_pkg::OFF_IRQ_CLEAR, 32'h0);
    capabilityMaskA <= 32'h0000_0000;
    wr(msrc_pkg::OFF_RESET_A, 32'h0000_0008);
    rd(msrc_pkg::OFF_RESET_A, 32'h0);
    rd(msrc_pkg::OFF_IRQ_STATUS, 32'h4);
    wr(msrc_pkg::OFF_RESET_B, 32'h1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(msrc_pkg::OFF_RESET_B, 32'h0);
    rd(msrc_pkg::OFF_IRQ_STATUS, 32'h0);
    settle();
    chk(resA | resB, 32'h0);
    wrapUp();
  end
endmodule : msrc_soft_reset_control_tb
